// [vsf_pkg.sv]
// package for the video sub-protocol filter
// assumes one 50 MHz clock and an active-low asynchronous reset
package vsf_pkg;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned PIX_W          = 24;
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned EDID_BYTES     = 256;
  localparam int unsigned EDID_AW        = 8;
  localparam int unsigned EDID_WAIT_US   = 20;
  localparam int unsigned EDID_WAIT_CYC  = (EDID_WAIT_US * (CLK_HZ / 1000000));
  localparam logic [7:0]  EDID_RST_BYTE  = 8'h00;

  // side-channel message kinds
  typedef enum logic [3:0] {
    SC_EDID_D2H, SC_HPD_D2H, SC_LINK_TRAIN, SC_EDID_H2D, SC_CEC,
    SC_HDCP, SC_MCCS, SC_ARC, SC_HEAC, SC_HEC, SC_OTHER
  } sc_kind_e;

  // direction of a side-channel message
  typedef enum logic {
    DIR_H2D, DIR_D2H
  } sc_dir_e;

  // connector protocol of an output or an input
  typedef enum logic [1:0] {
    PROTO_DP, PROTO_HDMI, PROTO_TYPEC
  } proto_e;

  typedef struct packed {
    logic [PIX_W-1:0] pixel;
    logic             hsync;
    logic             vsync;
    logic             de;
  } video_s;

  typedef struct packed {
    sc_kind_e   kind;
    sc_dir_e    dir;
    logic [7:0] data;
  } sc_msg_s;

  // decide whether a side-channel message may cross the given path
  function automatic logic sc_allowed(input proto_e p, input sc_kind_e k,
                                      input sc_dir_e d);
    logic ok;
    ok = 1'b0;
    if (k == SC_EDID_D2H && d == DIR_D2H) begin
      ok = 1'b1;
    end else if (k == SC_HPD_D2H && d == DIR_D2H) begin
      ok = 1'b1;
    end else if (k == SC_LINK_TRAIN && p != PROTO_HDMI) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : sc_allowed
endpackage : vsf_pkg

// [vsf_fifo.sv]
// small synchronous fifo carrying converted video words
// assumes a single clock; both sides use valid and ready
module vsf_fifo #(
  parameter int unsigned WIDTH = 27,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count_reg != DEPTH[AW:0]);
  assign rd_valid_out = (count_reg != '0);
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;
  assign rd_data_out  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : vsf_fifo

// [vsf_edid_mem.sv]
// edid copy memory, registered read data
// assumes single clock; one write port from the reader, one read port
module vsf_edid_mem #(
  parameter int unsigned AW = 8
) (
  input  wire logic          clock_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic [7:0]         rd_data_out
);
  logic [7:0] mem_reg [2**AW];

  always_ff @(posedge clock_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_reg[rd_addr_in];
  end
endmodule : vsf_edid_mem

// [video_subprotocol_filter.sv]
// video path and side-channel filter of a secure sharing switch
// assumes host video already parallel pixels; pins synchronous to clock_in
module video_subprotocol_filter
  import vsf_pkg::*;
#(
  parameter int unsigned NUM_DISP  = 2,
  parameter logic        HAS_TYPEC = 1'b1
) (
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  input  vsf_pkg::proto_e             in_proto_in,
  input  vsf_pkg::video_s             host_video_in,
  input  wire logic                   host_valid_in,
  output logic                        host_ready_out,
  input  vsf_pkg::proto_e             out_proto_in  [NUM_DISP],
  output vsf_pkg::video_s             disp_video_out [NUM_DISP],
  output logic                        disp_valid_out [NUM_DISP],
  output logic                        disp_is_dp_out [NUM_DISP],
  input  wire logic                   disp_ready_in  [NUM_DISP],
  input  vsf_pkg::sc_msg_s            host_sc_in,
  input  wire logic                   host_sc_valid_in,
  output vsf_pkg::sc_msg_s            disp_sc_out    [NUM_DISP],
  output logic                        disp_sc_valid_out [NUM_DISP],
  input  vsf_pkg::sc_msg_s            disp_sc_in     [NUM_DISP],
  input  wire logic                   disp_sc_valid_in [NUM_DISP],
  output vsf_pkg::sc_msg_s            host_sc_out,
  output logic                        host_sc_valid_out,
  output logic                        sc_dropped_out,
  input  wire logic [7:0]             edid_byte_in,
  input  wire logic                   edid_byte_valid_in,
  output logic                        edid_req_out,
  output logic                        edid_done_out,
  input  wire logic [EDID_AW-1:0]     host_edid_addr_in,
  output logic [7:0]                  host_edid_data_out
);
  import vsf_pkg::*;

  localparam int unsigned VW = $bits(video_s);

  typedef enum logic [1:0] {
    ED_WAIT, ED_READ, ED_DONE
  } edid_state_e;

  edid_state_e           ed_state_reg;
  logic [EDID_AW:0]      ed_count_reg;
  logic [15:0]           ed_wait_reg;
  logic                  input_ok;
  video_s                conv_video;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [VW-1:0]         fifo_out_data;
  logic                  fifo_in_ready;
  logic [NUM_DISP-1:0]   taken_reg;
  logic [NUM_DISP-1:0]   disp_rdy_vec;
  logic [NUM_DISP-1:0]   d2h_ok;
  logic [NUM_DISP-1:0]   h2d_ok;
  logic                  h2d_drop;
  logic                  d2h_drop;

  // accept only dp, hdmi, and type-c when the variant has it
  assign input_ok = (in_proto_in == PROTO_DP) ||
                    (in_proto_in == PROTO_HDMI) ||
                    (HAS_TYPEC && in_proto_in == PROTO_TYPEC);

  // dp and type-c input are not re-framed; every accepted protocol feeds the same internal stream;
  // pixel timing is kept as is, with no rescaling; pixel data is zeroed while de is low
  always_comb begin
    conv_video = host_video_in;
    if (!host_video_in.de) begin
      conv_video.pixel = '0;
    end
  end

  // ingress is refused until the monitor description is captured
  assign host_ready_out = fifo_in_ready && input_ok &&
                          (ed_state_reg == ED_DONE);

  vsf_fifo #(
    .WIDTH (VW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .wr_data_in   (conv_video),
    .wr_valid_in  (host_valid_in && input_ok && (ed_state_reg == ED_DONE)),
    .wr_ready_out (fifo_in_ready),
    .rd_data_out  (fifo_out_data),
    .rd_valid_out (fifo_out_valid),
    .rd_ready_in  (fifo_out_ready)
  );

  // fan-out: a word leaves the fifo once every display has taken it,
  // each display keeps its own handshake so one stall does not drop data
  always_comb begin
    for (int i = 0; i < NUM_DISP; i++) begin
      disp_rdy_vec[i] = taken_reg[i] || disp_ready_in[i];
    end
  end
  assign fifo_out_ready = fifo_out_valid && (&disp_rdy_vec);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      taken_reg <= '0;
    end else if (fifo_out_ready) begin
      taken_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_DISP; i++) begin
        if (fifo_out_valid && disp_ready_in[i]) begin
          taken_reg[i] <= 1'b1;
        end
      end
    end
  end

  // NUM_DISP=1 gives the single-monitor variant
  always_comb begin
    for (int i = 0; i < NUM_DISP; i++) begin
      disp_video_out[i] = fifo_out_data;
      disp_valid_out[i] = fifo_out_valid && !taken_reg[i];
      disp_is_dp_out[i] = (out_proto_in[i] == PROTO_DP);
    end
  end

  // edid capture, once per reset; no path back to the reader afterwards
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ed_state_reg <= ED_WAIT;
      ed_wait_reg  <= '0;
      ed_count_reg <= '0;
    end else begin
      case (ed_state_reg)
        ED_WAIT: begin
          if (ed_wait_reg == 16'(EDID_WAIT_CYC - 1)) begin
            ed_state_reg <= ED_READ;
          end else begin
            ed_wait_reg <= ed_wait_reg + 16'h0001;
          end
        end
        ED_READ: begin
          if (edid_byte_valid_in) begin
            ed_count_reg <= ed_count_reg + 1'b1;
            if (ed_count_reg == (EDID_AW+1)'(EDID_BYTES - 1)) begin
              ed_state_reg <= ED_DONE;
            end
          end
        end
        default: begin
          ed_state_reg <= ED_DONE;
        end
      endcase
    end
  end

  assign edid_req_out  = (ed_state_reg == ED_READ);
  assign edid_done_out = (ed_state_reg == ED_DONE);

  vsf_edid_mem #(
    .AW (EDID_AW)
  ) u_edid (
    .clock_in    (clock_in),
    .wr_en_in    ((ed_state_reg == ED_READ) && edid_byte_valid_in),
    .wr_addr_in  (ed_count_reg[EDID_AW-1:0]),
    .wr_data_in  (edid_byte_in),
    .rd_addr_in  (host_edid_addr_in),
    .rd_data_out (host_edid_data_out)
  );

  // side-channel whitelist, per display path and direction
  always_comb begin
    for (int i = 0; i < NUM_DISP; i++) begin
      h2d_ok[i] = host_sc_valid_in && (host_sc_in.dir == DIR_H2D) &&
                  sc_allowed(out_proto_in[i], host_sc_in.kind,
                             DIR_H2D);
      d2h_ok[i] = disp_sc_valid_in[i] && (disp_sc_in[i].dir == DIR_D2H) &&
                  sc_allowed(out_proto_in[i], disp_sc_in[i].kind,
                             DIR_D2H);
    end
  end

  assign h2d_drop = host_sc_valid_in && (h2d_ok == '0);
  always_comb begin
    d2h_drop = 1'b0;
    for (int i = 0; i < NUM_DISP; i++) begin
      if (disp_sc_valid_in[i] && !d2h_ok[i]) begin
        d2h_drop = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_DISP; i++) begin
        disp_sc_out[i]       <= '0;
        disp_sc_valid_out[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NUM_DISP; i++) begin
        disp_sc_valid_out[i] <= h2d_ok[i];
        disp_sc_out[i]       <= h2d_ok[i] ? host_sc_in : '0;
      end
    end
  end

  // display 0 wins when two displays report in the same cycle; the
  // other message is lost, acceptable for hpd levels that repeat
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_sc_out       <= '0;
      host_sc_valid_out <= 1'b0;
      sc_dropped_out    <= 1'b0;
    end else begin
      host_sc_valid_out <= |d2h_ok;
      host_sc_out       <= '0;
      for (int i = NUM_DISP - 1; i >= 0; i--) begin
        if (d2h_ok[i]) begin
          host_sc_out <= disp_sc_in[i];
        end
      end
      sc_dropped_out <= h2d_drop || d2h_drop;
    end
  end
endmodule : video_subprotocol_filter

// [vsf_asserts.sv]
// port checker for the video sub-protocol filter
// bound onto each filter instance; one clock, async active-low reset
module vsf_asserts
  import vsf_pkg::*;
#(
  parameter int unsigned NUM_DISP = 2
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  vsf_pkg::proto_e  out_proto_in      [NUM_DISP],
  input  vsf_pkg::sc_msg_s host_sc_in,
  input  wire logic        host_sc_valid_in,
  input  vsf_pkg::sc_msg_s disp_sc_in        [NUM_DISP],
  input  wire logic        disp_sc_valid_in  [NUM_DISP],
  input  wire logic        disp_sc_valid_out [NUM_DISP],
  input  wire logic        host_sc_valid_out,
  input  wire logic        sc_dropped_out,
  input  wire logic        host_ready_out,
  input  wire logic        edid_req_out,
  input  wire logic        edid_done_out,
  input  wire logic        disp_valid_out    [NUM_DISP],
  input  wire logic        disp_ready_in     [NUM_DISP],
  input  wire logic        disp_is_dp_out    [NUM_DISP]
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_edid0;
    disp_sc_valid_in[0] && disp_sc_in[0].kind == SC_EDID_D2H &&
      disp_sc_in[0].dir == DIR_D2H;
  endsequence
  sequence s_h2d_bad;
    host_sc_valid_in &&
      host_sc_in.kind inside {SC_CEC, SC_HDCP, SC_MCCS, SC_EDID_H2D};
  endsequence
  a_ready_after_edid: assert property (
    host_ready_out |-> edid_done_out) else $error("video before edid");
  a_done_no_reread: assert property (
    edid_done_out |=> edid_done_out && !edid_req_out)
    else $error("edid read again");
  a_dp_flag_match: assert property (
    disp_is_dp_out[0] == (out_proto_in[0] == PROTO_DP))
    else $error("output kind wrong");
  a_h2d_blocked: assert property (
    s_h2d_bad |=> !disp_sc_valid_out[0] && sc_dropped_out)
    else $error("host message leaked");
  a_hdmi_extras_blocked: assert property (
    host_sc_valid_in && host_sc_in.kind inside {SC_ARC, SC_HEAC, SC_HEC}
      |=> !disp_sc_valid_out[0] && sc_dropped_out)
    else $error("hdmi extra leaked");
  a_hdmi_no_train: assert property (
    host_sc_valid_in && host_sc_in.kind == SC_LINK_TRAIN &&
      out_proto_in[0] == PROTO_HDMI |=> !disp_sc_valid_out[0])
    else $error("training on hdmi");
  a_edid_to_host: assert property (
    s_edid0 |=> host_sc_valid_out) else $error("edid not passed");
  a_other_dropped: assert property (
    disp_sc_valid_in[0] && disp_sc_in[0].kind == SC_OTHER &&
      !disp_sc_valid_in[NUM_DISP-1] && !host_sc_valid_in
      |=> !host_sc_valid_out && sc_dropped_out)
    else $error("unknown message passed");
  a_video_holds: assert property (
    disp_valid_out[0] && !disp_ready_in[0] |=> disp_valid_out[0])
    else $error("video word lost");
endmodule : vsf_asserts
bind video_subprotocol_filter vsf_asserts #(.NUM_DISP(NUM_DISP))
  vsf_asserts_inst (.*);

// [vsf_display_model.sv]
// display-side model: edid byte source and stalling video sink
// one clock; bytes follow a pattern that the bench recomputes
module vsf_display_model (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic edid_req_in,
  input  wire logic slow_in,
  output logic [7:0] edid_byte_out,
  output logic       edid_valid_out,
  output logic       ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] idx_reg;
  logic [1:0] ph_reg;
  wire  [8:0] idx_next = idx_reg + {8'h00, edid_valid_out};
  wire        more = edid_req_in && (idx_next < 9'h100);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_reg <= 9'h000;
      edid_valid_out <= 1'b0;
      edid_byte_out <= 8'h00;
    end else begin
      idx_reg <= idx_next;
      edid_valid_out <= more;
      // idle bytes flip so stale data never looks valid
      edid_byte_out <= more ? (idx_next[7:0] ^ 8'hA5) : ~edid_byte_out;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_reg <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      ready_out <= !slow_in || (ph_reg == 2'h3);
    end
  end
endmodule : vsf_display_model

// [vsf_tb.sv]
// bench: edid capture, side-channel filtering, buffered video
// two display models; the first also supplies edid bytes
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import vsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in, rst_n_in, host_valid_in, host_ready_out, slow1;
  logic rdy0, rdy1, host_sc_valid_in, host_sc_valid_out, sc_dropped_out;
  logic edid_byte_valid_in, edid_req_out, edid_done_out;
  logic [7:0] edid_byte_in, host_edid_addr_in, host_edid_data_out;
  proto_e in_proto_in, out_proto_in [2];
  video_s host_video_in, disp_video_out [2], exp_w [16];
  logic disp_valid_out [2], disp_is_dp_out [2], disp_ready_in [2];
  logic disp_sc_valid_out [2], disp_sc_valid_in [2];
  sc_msg_s host_sc_in, host_sc_out, disp_sc_out [2], disp_sc_in [2];
  int mismatches, n_tests, rx [2];
  assign disp_ready_in = '{rdy0, rdy1};
  video_subprotocol_filter #(.NUM_DISP(2), .HAS_TYPEC(1'b1))
    video_subprotocol_filter_inst (.*);
  vsf_display_model disp0_model (.clock_in, .rst_n_in,
    .edid_req_in(edid_req_out), .slow_in(1'b0), .ready_out(rdy0),
    .edid_byte_out(edid_byte_in), .edid_valid_out(edid_byte_valid_in));
  vsf_display_model disp1_model (.clock_in, .rst_n_in, .edid_req_in(1'b0),
    .slow_in(slow1), .ready_out(rdy1), .edid_byte_out(), .edid_valid_out());
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    for (int d = 0; d < 2; d++) begin
      if ((rst_n_in & disp_valid_out[d] & disp_ready_in[d]) === 1'b1) begin
        `CHK("video", exp_w[rx[d]], disp_video_out[d])
        rx[d]++;
      end
    end
  end
  task complete_run;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task guard(input logic ok);
    if (!ok) begin
      mismatches++;
      complete_run();
    end
  endtask : guard
  task do_reset;
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    `CHK("req_rst", 1'b0, edid_req_out)
    `CHK("done_rst", 1'b0, edid_done_out)
    rst_n_in <= 1'b1;
  endtask : do_reset
  task t_edid;
    int n;
    n = 0;
    while (!edid_req_out && n < 1100) begin
      @(posedge clock_in);
      n++;
    end
    guard(n < 1100);
    `CHK("wait", EDID_WAIT_CYC + 1, n)
    n = 0;
    while (!edid_done_out && n < 300) begin
      `CHK("no_video", 1'b0, host_ready_out)
      @(posedge clock_in);
      n++;
    end
    guard(n < 300);
    for (int a = 0; a < 256; a += 255) begin
      host_edid_addr_in <= 8'(a);
      repeat (2) @(posedge clock_in);
      `CHK("edid", 8'(a) ^ 8'hA5, host_edid_data_out)
    end
  endtask : t_edid
  task t_sc;
    logic e0, e1;
    for (int p = 0; p < 2; p++) begin
      if (p == 0) begin
        out_proto_in <= '{PROTO_DP, PROTO_HDMI};
      end else begin
        out_proto_in <= '{PROTO_HDMI, PROTO_DP};
      end
      for (int k = 0; k < 11; k++) begin
        host_sc_in <= '{sc_kind_e'(k), DIR_H2D, 8'(k)};
        host_sc_valid_in <= 1'b1;
        @(posedge clock_in);
        host_sc_valid_in <= 1'b0;
        @(posedge clock_in);
        e0 = (k == 2) && (p == 0);
        e1 = (k == 2) && (p == 1);
        `CHK("fwd0", e0, disp_sc_valid_out[0])
        `CHK("fwd1", e1, disp_sc_valid_out[1])
        if (e0) `CHK("fwd0_data", 8'(k), disp_sc_out[0].data)
        if (e1) `CHK("fwd1_data", 8'(k), disp_sc_out[1].data)
        if (k != 2) `CHK("drop", 1'b1, sc_dropped_out)
        for (int d = 0; d < 2; d++) begin
          disp_sc_in[d] <= '{sc_kind_e'(k), DIR_D2H, 8'(k)};
          disp_sc_valid_in[d] <= 1'b1;
          @(posedge clock_in);
          disp_sc_valid_in[d] <= 1'b0;
          @(posedge clock_in);
          e0 = (k < 2) || (k == 2 && d == p);
          `CHK("to_host", e0, host_sc_valid_out)
          if (e0) begin
            `CHK("data", 8'(k), host_sc_out.data)
            `CHK("d_keep", 1'b0, sc_dropped_out)
          end else begin
            `CHK("d_drop", 1'b1, sc_dropped_out)
          end
        end
      end
    end
  endtask : t_sc
  task t_video;
    video_s w;
    int n, full;
    full = 0;
    out_proto_in <= '{PROTO_DP, PROTO_HDMI};
    in_proto_in <= proto_e'(2'h3);
    host_valid_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHK("bad_proto", 1'b0, host_ready_out)
    `CHK("dp0", 1'b1, disp_is_dp_out[0])
    `CHK("dp1", 1'b0, disp_is_dp_out[1])
    slow1 <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      w = '{24'h0F0F0F ^ 24'(i), i[0], i[1], (i % 3) != 0};
      exp_w[i] = w;
      if (!w.de) exp_w[i].pixel = '0;
      // cycle through dp, hdmi and type-c inputs so each is accepted
      in_proto_in <= proto_e'(i % 3);
      host_video_in <= w;
      n = 0;
      do begin
        @(posedge clock_in);
        n++;
        if (!host_ready_out) full++;
      end while (!host_ready_out && n < 100);
      guard(n < 100);
    end
    host_valid_in <= 1'b0;
    n = 0;
    while ((rx[0] < 16 || rx[1] < 16) && n < 200) begin
      @(posedge clock_in);
      n++;
    end
    guard(n < 200);
    @(posedge clock_in);
    `CHK("refused", 1'b1, full > 0)
    `CHK("drained", 1'b0, disp_valid_out[1])
  endtask : t_video
  initial begin
    rst_n_in = 1'b0;
    slow1 = 1'b0;
    in_proto_in = PROTO_DP;
    host_video_in = '0;
    host_valid_in = 1'b0;
    out_proto_in = '{PROTO_DP, PROTO_HDMI};
    host_sc_in = '0;
    host_sc_valid_in = 1'b0;
    disp_sc_in = '{default: '0};
    disp_sc_valid_in = '{1'b0, 1'b0};
    host_edid_addr_in = 8'h00;
    mismatches = 0;
    n_tests = 0;
    rx = '{0, 0};
    do_reset();
    t_edid();
    t_sc();
    t_video();
    // a reboot must capture the edid afresh
    do_reset();
    t_edid();
    complete_run();
  end
endmodule : testbench
